// file: shared/apso_pkg.sv
// Summary of operation
// - a new sample is captured on every rising edge of the conversion clock
// - each sample's word appears three and a half conversion-clock cycles after its capture edge
// - sample bits and overrange flag change only on the conversion clock falling edge
// - overrange flag is high for an input beyond full scale, else low
// - output word is 13 bits wide, bit 0 is lsb, bit 12 is msb
// - sample strobe is an inverted copy of the conversion clock
// - strobe rises one clock-high time after it falls, whatever the duty cycle
// - words are offset binary: most negative is all zeros, mid-scale is msb only
`default_nettype none
package apso_pkg;
   localparam int SAMPLE_W = 13;
   localparam int LATENCY = 4;
   localparam int FIFO_DEPTH = 8;
   localparam int SYNC_STAGES = 2;
   localparam int OVR_POS = SAMPLE_W;
   localparam int WORD_W = SAMPLE_W + 1;
   localparam logic [WORD_W-1:0] WORD_RST = 14'h0000;
   localparam logic [SAMPLE_W-1:0] MID_CODE = 13'h1000;
   localparam logic [SAMPLE_W-1:0] CODE_TOP = 13'h1fff;
   localparam logic [SAMPLE_W-1:0] CODE_BOT = 13'h0000;
endpackage : apso_pkg
`default_nettype wire

// file: shared/apso_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface apso_stream_if #(
   parameter int WIDTH = apso_pkg::WORD_W
);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : apso_stream_if
`default_nettype wire

// file: rtl/apso_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module apso_fifo #(
   parameter int WIDTH = apso_pkg::WORD_W,
   parameter int DEPTH = apso_pkg::FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic cken,
   apso_stream_if.snk wr,
   apso_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("apso_fifo depth must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_ptr_q;
   logic [AW:0] rd_ptr_q;
   logic full;
   logic empty;
   logic push;
   logic pop;

   // full when pointers differ only in the wrap bit
   assign full = (wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                 (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
   assign empty = (wr_ptr_q == rd_ptr_q);
   assign wr.ready = cken && !full;
   assign rd.valid = !empty;
   assign rd.data = mem_q[rd_ptr_q[AW-1:0]];
   assign push = wr.valid && wr.ready;
   assign pop = cken && rd.valid && rd.ready;

   always_ff @(posedge mclk) begin
      if (push) begin
         mem_q[wr_ptr_q[AW-1:0]] <= wr.data;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         wr_ptr_q <= '0;
      end else if (push) begin
         wr_ptr_q <= wr_ptr_q + 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rd_ptr_q <= '0;
      end else if (pop) begin
         rd_ptr_q <= rd_ptr_q + 1'b1;
      end
   end
endmodule : apso_fifo
`default_nettype wire

// file: rtl/apso_sample_out.sv
`timescale 1ns/1ps
`default_nettype none
module apso_sample_out #(
   parameter int SAMPLE_W = apso_pkg::SAMPLE_W,
   parameter int LATENCY = apso_pkg::LATENCY,
   parameter int FIFO_DEPTH = apso_pkg::FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic cken,
   input wire logic conv_clk,
   input wire logic signed [SAMPLE_W:0] analog_input_pair,
   output logic [SAMPLE_W-1:0] sample_bits,
   output logic overrange_flag,
   output logic sample_strobe,
   output logic [SAMPLE_W:0] mon_data,
   output logic mon_valid,
   input wire logic mon_ready
);
   localparam int WW = SAMPLE_W + 1;
   localparam logic signed [SAMPLE_W:0] IN_MAX =
      {2'b00, {(SAMPLE_W-1){1'b1}}};
   localparam logic signed [SAMPLE_W:0] IN_MIN =
      {2'b11, {(SAMPLE_W-1){1'b0}}};

   if (SAMPLE_W != apso_pkg::SAMPLE_W || LATENCY < 2) begin : g_chk
      $error("apso_sample_out: unsupported width or latency");
   end

   // quantise and code one captured input
   function automatic logic [WW-1:0] code_word(
      input logic signed [SAMPLE_W:0] vin
   );
      logic [WW-1:0] w;
      w = '0;
      if (vin > IN_MAX) begin
         w = {1'b1, apso_pkg::CODE_TOP};
      end else if (vin < IN_MIN) begin
         w = {1'b1, apso_pkg::CODE_BOT};
      end else begin
         w = {1'b0, vin[SAMPLE_W-1:0] ^ apso_pkg::MID_CODE};
      end
      return w;
   endfunction : code_word

   // conversion clock domain
   logic [apso_pkg::SYNC_STAGES-1:0] rst_sync_q;
   logic [apso_pkg::SYNC_STAGES-1:0] ce_sync_q;
   logic [apso_pkg::SYNC_STAGES-1:0] ack_sync_q;
   logic rstn_c;
   logic ce_c;
   logic ack_c;
   logic [WW-1:0] pipe_q [LATENCY];
   logic [WW-1:0] out_q;
   logic pos_tog_q;
   logic neg_tog_q;
   logic req_q;
   logic [WW-1:0] snap_q;
   logic ack_q;

   always_ff @(posedge conv_clk) begin
      rst_sync_q <= {rst_sync_q[0], rstn};
   end

   always_ff @(posedge conv_clk) begin
      ce_sync_q <= {ce_sync_q[0], cken};
   end

   always_ff @(posedge conv_clk) begin
      ack_sync_q <= {ack_sync_q[0], ack_q};
   end

   assign rstn_c = rst_sync_q[apso_pkg::SYNC_STAGES-1];
   assign ce_c = ce_sync_q[apso_pkg::SYNC_STAGES-1];
   assign ack_c = ack_sync_q[apso_pkg::SYNC_STAGES-1];

   // capture stage on each rising edge
   always_ff @(posedge conv_clk) begin
      if (!rstn_c) begin
         pipe_q[0] <= apso_pkg::WORD_RST;
      end else if (ce_c) begin
         pipe_q[0] <= code_word(analog_input_pair);
      end
   end

   // remaining pipeline stages
   for (genvar i = 1; i < LATENCY; i++) begin : g_pipe
      always_ff @(posedge conv_clk) begin
         if (!rstn_c) begin
            pipe_q[i] <= apso_pkg::WORD_RST;
         end else if (ce_c) begin
            pipe_q[i] <= pipe_q[i-1];
         end
      end
   end

   // output word launched on the falling edge
   always_ff @(negedge conv_clk) begin
      if (!rstn_c) begin
         out_q <= apso_pkg::WORD_RST;
      end else if (ce_c) begin
         out_q <= pipe_q[LATENCY-1];
      end
   end

   assign sample_bits = out_q[SAMPLE_W-1:0];
   assign overrange_flag = out_q[apso_pkg::OVR_POS];

   // strobe low after rising edge, high after falling edge
   always_ff @(posedge conv_clk) begin
      if (!rstn_c) begin
         pos_tog_q <= 1'b0;
      end else if (ce_c) begin
         pos_tog_q <= ~pos_tog_q;
      end
   end

   always_ff @(negedge conv_clk) begin
      if (!rstn_c) begin
         neg_tog_q <= 1'b0;
      end else if (ce_c) begin
         neg_tog_q <= pos_tog_q;
      end
   end

   // only one of the two flops moves per edge, so no glitch
   assign sample_strobe = (neg_tog_q == pos_tog_q);

   // monitor tap: toggle handshake toward mclk
   always_ff @(posedge conv_clk) begin
      if (!rstn_c) begin
         req_q <= 1'b0;
         snap_q <= apso_pkg::WORD_RST;
      end else if (ce_c && (req_q == ack_c)) begin
         snap_q <= pipe_q[LATENCY-1];
         req_q <= ~req_q;
      end
   end

   // mclk domain
   logic [apso_pkg::SYNC_STAGES-1:0] req_sync_q;
   logic req_m;

   apso_stream_if #(.WIDTH(WW)) wr_if ();
   apso_stream_if #(.WIDTH(WW)) rd_if ();

   always_ff @(posedge mclk) begin
      if (cken) begin
         req_sync_q <= {req_sync_q[0], req_q};
      end
   end

   assign req_m = req_sync_q[apso_pkg::SYNC_STAGES-1];
   assign wr_if.valid = (req_m != ack_q);
   assign wr_if.data = snap_q;

   // ack only when the buffer takes the word
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         ack_q <= 1'b0;
      end else if (cken && wr_if.valid && wr_if.ready) begin
         ack_q <= ~ack_q;
      end
   end

   apso_fifo #(
      .WIDTH(WW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .rstn(rstn),
      .cken(cken),
      .wr(wr_if.snk),
      .rd(rd_if.src)
   );

   assign mon_data = rd_if.data;
   assign mon_valid = rd_if.valid;
   assign rd_if.ready = mon_ready;
endmodule : apso_sample_out
`default_nettype wire

// file: test/apso_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module apso_rx_model (
   input wire logic sample_strobe,
   input wire logic [12:0] sample_bits,
   input wire logic overrange_flag,
   output logic [13:0] rx_word
);
   // capture on strobe rise, 1 ns later stands in for receiver clock delay
   always @(posedge sample_strobe) begin
      #1;
      rx_word <= {overrange_flag, sample_bits};
   end
endmodule : apso_rx_model
`default_nettype wire

// file: test/apso_sample_out_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module apso_sample_out_assertions (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic conv_clk,
   input wire logic signed [13:0] analog_input_pair,
   input wire logic [12:0] sample_bits,
   input wire logic overrange_flag,
   input wire logic sample_strobe,
   input wire logic [13:0] mon_data,
   input wire logic mon_valid,
   input wire logic mon_ready
);
   logic [13:0] hold_q;
   logic [13:0] pipe_q [4];
   logic [3:0] live_q;
   function automatic logic [13:0] ex(input logic signed [13:0] v);
      if (v > 14'sd4095) return 14'h3fff;
      if (v < -14'sd4096) return 14'h2000;
      return {1'b0, v[12:0] ^ 13'h1000};
   endfunction : ex
   always_ff @(posedge conv_clk) hold_q <= {overrange_flag, sample_bits};
   always_ff @(posedge conv_clk) begin
      pipe_q[0] <= ex(analog_input_pair);
      for (int i = 1; i < 4; i++) pipe_q[i] <= pipe_q[i-1];
   end
   always_ff @(posedge conv_clk) begin
      if (!rstn) live_q <= 4'h0;
      else if (live_q != 4'hf) live_q <= live_q + 4'h1;
   end
   a_strobe_high_rise: assert property (@(posedge conv_clk) disable iff (!rstn)
      sample_strobe) else $error("strobe low at rising edge");
   a_strobe_low_fall: assert property (@(negedge conv_clk) disable iff (!rstn)
      live_q == 4'hf |-> !sample_strobe) else $error("strobe high at fall");
   a_data_fall_only: assert property (@(negedge conv_clk) disable iff (!rstn)
      {overrange_flag, sample_bits} == hold_q) else $error("data moved");
   a_code_latency: assert property (@(posedge conv_clk) disable iff (!rstn)
      live_q == 4'hf |-> sample_bits == pipe_q[3][12:0])
      else $error("code mismatch");
   a_flag_latency: assert property (@(posedge conv_clk) disable iff (!rstn)
      live_q == 4'hf |-> overrange_flag == pipe_q[3][13])
      else $error("flag mismatch");
   a_mid_scale: assert property (@(posedge conv_clk) disable iff (!rstn)
      live_q == 4'hf && $past(analog_input_pair, 4) == 14'sd0
      |-> sample_bits == 13'h1000) else $error("mid-scale code wrong");
   a_top_clamp: assert property (@(posedge conv_clk) disable iff (!rstn)
      live_q == 4'hf && $past(analog_input_pair, 4) > 14'sd4095
      |-> overrange_flag && sample_bits == 13'h1fff) else $error("clamp");
   a_mon_hold: assert property (@(posedge mclk) disable iff (!rstn)
      mon_valid && !mon_ready |=> mon_valid && $stable(mon_data))
      else $error("monitor word dropped");
   c_pop: cover property (@(posedge mclk) mon_valid && mon_ready);
   c_ovr: cover property (@(posedge conv_clk) overrange_flag);
   c_mid: cover property (@(posedge conv_clk) sample_bits == 13'h1000);
endmodule : apso_sample_out_assertions
bind apso_sample_out apso_sample_out_assertions u_apso_sample_out_assertions (
   .mclk, .rstn, .conv_clk, .analog_input_pair, .sample_bits, .overrange_flag,
   .sample_strobe, .mon_data, .mon_valid, .mon_ready);
`default_nettype wire

// file: test/apso_sample_out_test.sv
`timescale 1ns/1ps
`default_nettype none
module apso_sample_out_test;
   logic mclk = 1'b0;
   logic conv_clk = 1'b0;
   logic rstn = 1'b0;
   logic mon_ready = 1'b0;
   logic signed [13:0] vin = 14'sh0000;
   logic [12:0] sample_bits;
   logic overrange_flag, sample_strobe, mon_valid;
   logic [13:0] mon_data, rx_word;
   int err_count = 0;
   int n_checks = 0;
   always #50 mclk = ~mclk;
   initial #7 forever #15 conv_clk = ~conv_clk;
   apso_sample_out u_apso_sample_out (.mclk, .rstn, .cken(1'b1), .conv_clk,
      .analog_input_pair(vin), .sample_bits, .overrange_flag, .sample_strobe,
      .mon_data, .mon_valid, .mon_ready);
   apso_rx_model u_apso_rx_model (.sample_strobe, .sample_bits,
      .overrange_flag, .rx_word);
   function automatic logic [13:0] ex(input logic signed [13:0] v);
      if (v > 14'sd4095) return 14'h3fff;
      if (v < -14'sd4096) return 14'h2000;
      return {1'b0, v[12:0] ^ 13'h1000};
   endfunction : ex
   task automatic chk(input logic [13:0] got, input logic [13:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic close_out;
      $display("errors=%0d checks=%0d", err_count, n_checks);
      if (err_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out
   task automatic t_reset;
      chk({overrange_flag, sample_bits}, 14'h0000);
      chk({12'h000, mon_valid, sample_strobe}, 14'h0001);
   endtask : t_reset
   task automatic t_codes;
      logic signed [13:0] tbl [8] = '{-14'sd4096, -14'sd1, 14'sd0, 14'sd4095,
         14'sd4096, -14'sd4097, 14'sd1, 14'sd1365};
      for (int i = 0; i < 13; i++) begin
         @(posedge conv_clk);
         vin <= tbl[i % 8];
         #1;
         if (i >= 5) chk(rx_word, ex(tbl[(i - 5) % 8]));
      end
   endtask : t_codes
   task automatic t_fifo;
      @(posedge conv_clk);
      vin <= -14'sd1;
      @(posedge mclk);
      mon_ready <= 1'b1;
      repeat (40) @(posedge mclk);
      mon_ready <= 1'b0;
      repeat (100) @(posedge mclk);
      mon_ready <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         #1;
         chk({13'h0000, mon_valid}, 14'h0001);
         chk(mon_data, ex(-14'sd1));
         @(posedge mclk);
      end
   endtask : t_fifo
   initial begin
      repeat (5) @(posedge mclk);
      t_reset();
      rstn <= 1'b1;
      repeat (20) @(posedge mclk);
      t_codes();
      t_fifo();
      close_out();
   end
   initial begin
      #200000;
      err_count++;
      close_out();
   end
endmodule : apso_sample_out_test
`default_nettype wire
